// >>> design/ldcfg_pkg.sv
// Constants and types for the link deserializer configuration register bank
package ldcfg_pkg;
   // Register offsets on the plain register port
   localparam logic [7:0] REG_PARTNER_ADDR = 8'h00;
   localparam logic [7:0] REG_OWN_ADDR = 8'h01;
   localparam logic [7:0] REG_SPREAD_CFG = 8'h02;
   localparam logic [7:0] REG_RANGE_STATUS = 8'h03;

   // Field positions
   localparam int ADDR_LSB = 1;
   localparam int SS_LSB = 6;
   localparam int PRNG_LSB = 2;
   localparam int SRNG_LSB = 0;

   // Spread select codes
   localparam logic [1:0] SS_NONE = 2'h0;
   localparam logic [1:0] SS_2PCT = 2'h1;
   localparam logic [1:0] SS_NONE_ALT = 2'h2;
   localparam logic [1:0] SS_4PCT = 2'h3;

   // Range field codes
   localparam logic [1:0] PCLK_12_25 = 2'h0;
   localparam logic [1:0] PCLK_25_50 = 2'h1;
   localparam logic [1:0] PCLK_50_104 = 2'h2;
   localparam logic [1:0] RATE_05_1 = 2'h0;
   localparam logic [1:0] RATE_1_2 = 2'h1;
   localparam logic [1:0] RATE_2_3125 = 2'h2;
   localparam logic [1:0] RANGE_AUTO = 2'h3;

   // Values after reset
   localparam logic [1:0] PRNG_RST = RANGE_AUTO;
   localparam logic [1:0] SRNG_RST = RANGE_AUTO;
   localparam logic [6:0] ADDR_RST = 7'h00;

   // Three-level strap encodings
   localparam logic [1:0] STRAP_LOW = 2'h0;
   localparam logic [1:0] STRAP_MID = 2'h1;
   localparam logic [1:0] STRAP_HIGH = 2'h2;

   // Fixed middle bits of the strapped addresses
   localparam logic [1:0] OWN_ADDR_MID = 2'h1;
   localparam logic [1:0] PARTNER_ADDR_MID = 2'h0;

   typedef enum logic [1:0] {
      LDCFG_SPREAD_OFF = 2'b00,
      LDCFG_SPREAD_2PCT = 2'b01,
      LDCFG_SPREAD_4PCT = 2'b10
   } ldcfg_spread_t;

   typedef enum logic [0:0] {
      LDCFG_ST_STRAP = 1'b0,
      LDCFG_ST_RUN = 1'b1
   } ldcfg_phase_t;

   typedef struct packed {
      ldcfg_phase_t phase;
      logic [6:0] own_addr;
      logic [6:0] partner_addr;
      logic [1:0] ss;
      ldcfg_spread_t spread;
      logic [1:0] prng;
      logic [1:0] srng;
      logic [1:0] pclk_eff;
      logic pclk_auto;
      logic [1:0] rate_eff;
      logic rate_auto;
      logic [7:0] rdata;
   } ldcfg_state_t;
endpackage

// >>> design/ldcfg_range_pick.sv
// Picks the fixed range from a field or the detected range when the field asks for auto
module ldcfg_range_pick #(
   parameter int W = 2
) (
   input wire logic [W-1:0] field,
   input wire logic [W-1:0] detected,
   output logic [W-1:0] range,
   output logic auto_on
);
   // All-ones code means automatic detection
   assign auto_on = (field == {W{1'b1}}); // [RULE6] [RULE8]
   assign range = auto_on ? detected : field; // [RULE5] [RULE7]
endmodule

// >>> design/ldcfg_regs.sv
// Configuration register bank: link addresses, spread select and range fields
// Summary of operation
// [RULE1] Own address in bits 7..1, strap default
// [RULE2] Partner address copy, also strap default
// [RULE3] Spread 00/10 none, 11 four percent
// [RULE4] Spread 01 two percent, strap high default
// [RULE5] Pixel clock range codes 00, 01, 10
// [RULE6] Pixel range code 11 means auto detect
// [RULE7] Serial rate range codes 00, 01, 10
// [RULE8] Serial rate code 11 means auto detect
// [RULE9] Reserved bits read zero, write zero
module ldcfg_regs (
   input wire logic clk,
   input wire logic rst,
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr_stb,
   input wire logic rd_stb,
   output logic [7:0] rdata,
   input wire logic [1:0] address_strap_a,
   input wire logic [1:0] address_strap_b,
   input wire logic spread_strap_pin,
   input wire logic [1:0] pclk_detect_range,
   input wire logic [1:0] rate_detect_range,
   output logic [6:0] own_link_address,
   output logic [6:0] partner_link_address,
   output logic [1:0] spread_mode,
   output logic [1:0] pclk_range,
   output logic pclk_auto,
   output logic [1:0] rate_range,
   output logic rate_auto,
   output logic cfg_ready
);
   ldcfg_pkg::ldcfg_state_t st_q;
   ldcfg_pkg::ldcfg_state_t st_d;
   logic [1:0] pclk_pick;
   logic pclk_pick_auto;
   logic [1:0] rate_pick;
   logic rate_pick_auto;

   // Three-level strap: the unused code 11 is read as high
   function automatic logic [1:0] strap_level(input logic [1:0] raw);
      strap_level = (raw == ldcfg_pkg::STRAP_LOW) ? ldcfg_pkg::STRAP_LOW :
                    (raw == ldcfg_pkg::STRAP_MID) ? ldcfg_pkg::STRAP_MID :
                    ldcfg_pkg::STRAP_HIGH;
   endfunction

   // Strapped address: strap b, fixed middle pair, strap a, zero
   function automatic logic [6:0] strap_addr(input logic [1:0] sb, input logic [1:0] sa,
                                             input logic [1:0] mid);
      strap_addr = {strap_level(sb), mid, strap_level(sa), 1'b0};
   endfunction

   function automatic ldcfg_pkg::ldcfg_spread_t spread_of(input logic [1:0] code);
      case (code)
         ldcfg_pkg::SS_2PCT: spread_of = ldcfg_pkg::LDCFG_SPREAD_2PCT;
         ldcfg_pkg::SS_4PCT: spread_of = ldcfg_pkg::LDCFG_SPREAD_4PCT;
         default: spread_of = ldcfg_pkg::LDCFG_SPREAD_OFF;
      endcase
   endfunction

   ldcfg_range_pick #(
      .W(2)
   ) u_pclk_pick (
      .field(st_q.prng),
      .detected(pclk_detect_range),
      .range(pclk_pick),
      .auto_on(pclk_pick_auto)
   );

   ldcfg_range_pick #(
      .W(2)
   ) u_rate_pick (
      .field(st_q.srng),
      .detected(rate_detect_range),
      .range(rate_pick),
      .auto_on(rate_pick_auto)
   );

   always_comb begin
      st_d = st_q;
      st_d.rdata = 8'h00;
      // Effective ranges follow the field, or the detector in auto mode
      st_d.pclk_eff = pclk_pick; // [RULE5] [RULE6]
      st_d.pclk_auto = pclk_pick_auto; // [RULE6]
      st_d.rate_eff = rate_pick; // [RULE7] [RULE8]
      st_d.rate_auto = rate_pick_auto; // [RULE8]
      case (st_q.phase)
         ldcfg_pkg::LDCFG_ST_STRAP: begin
            // Straps are caught at the first edge after reset, not under it
            st_d.own_addr = strap_addr(address_strap_b, address_strap_a, ldcfg_pkg::OWN_ADDR_MID); // [RULE1]
            st_d.partner_addr = strap_addr(address_strap_b, address_strap_a,
                                           ldcfg_pkg::PARTNER_ADDR_MID); // [RULE2]
            st_d.ss = spread_strap_pin ? ldcfg_pkg::SS_2PCT : ldcfg_pkg::SS_NONE; // [RULE3] [RULE4]
            st_d.phase = ldcfg_pkg::LDCFG_ST_RUN;
         end
         ldcfg_pkg::LDCFG_ST_RUN: begin
            if (wr_stb) begin
               // Reserved bits are dropped on write
               case (addr)
                  ldcfg_pkg::REG_PARTNER_ADDR: st_d.partner_addr = wdata[7:1]; // [RULE2] [RULE9]
                  ldcfg_pkg::REG_OWN_ADDR: st_d.own_addr = wdata[7:1]; // [RULE1] [RULE9]
                  ldcfg_pkg::REG_SPREAD_CFG: begin
                     st_d.ss = wdata[7:6]; // [RULE3] [RULE4]
                     st_d.prng = wdata[3:2]; // [RULE5]
                     st_d.srng = wdata[1:0]; // [RULE7]
                  end
                  default: begin
                  end
               endcase
            end
            if (rd_stb) begin
               case (addr)
                  ldcfg_pkg::REG_PARTNER_ADDR: st_d.rdata = {st_q.partner_addr, 1'b0}; // [RULE9]
                  ldcfg_pkg::REG_OWN_ADDR: st_d.rdata = {st_q.own_addr, 1'b0}; // [RULE9]
                  ldcfg_pkg::REG_SPREAD_CFG: st_d.rdata = {st_q.ss, 2'b00, st_q.prng, st_q.srng}; // [RULE9]
                  ldcfg_pkg::REG_RANGE_STATUS: st_d.rdata = {2'b00, st_q.rate_auto, st_q.pclk_auto,
                                                             st_q.pclk_eff, st_q.rate_eff};
                  default: st_d.rdata = 8'h00;
               endcase
            end
         end
         default: st_d.phase = ldcfg_pkg::LDCFG_ST_STRAP;
      endcase
      st_d.spread = spread_of(st_d.ss); // [RULE3] [RULE4]
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_q.phase <= ldcfg_pkg::LDCFG_ST_STRAP;
         st_q.own_addr <= ldcfg_pkg::ADDR_RST;
         st_q.partner_addr <= ldcfg_pkg::ADDR_RST;
         st_q.ss <= ldcfg_pkg::SS_NONE;
         st_q.spread <= ldcfg_pkg::LDCFG_SPREAD_OFF;
         st_q.prng <= ldcfg_pkg::PRNG_RST;
         st_q.srng <= ldcfg_pkg::SRNG_RST;
         st_q.pclk_eff <= ldcfg_pkg::PCLK_12_25;
         st_q.pclk_auto <= 1'b0;
         st_q.rate_eff <= ldcfg_pkg::RATE_05_1;
         st_q.rate_auto <= 1'b0;
         st_q.rdata <= 8'h00;
      end else begin
         st_q <= st_d;
      end
   end

   assign rdata = st_q.rdata;
   assign own_link_address = st_q.own_addr;
   assign partner_link_address = st_q.partner_addr;
   assign spread_mode = st_q.spread;
   assign pclk_range = st_q.pclk_eff;
   assign pclk_auto = st_q.pclk_auto;
   assign rate_range = st_q.rate_eff;
   assign rate_auto = st_q.rate_auto;
   assign cfg_ready = (st_q.phase == ldcfg_pkg::LDCFG_ST_RUN);

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   // The edge where ready rises is the same one that catches the straps

   own_strap_a: assert property ( // [RULE1]
      $rose(cfg_ready) |-> own_link_address ==
         strap_addr($past(address_strap_b), $past(address_strap_a), ldcfg_pkg::OWN_ADDR_MID))
      else $error("own address not taken from straps");

   partner_strap_a: assert property ( // [RULE2]
      $rose(cfg_ready) |-> partner_link_address ==
         strap_addr($past(address_strap_b), $past(address_strap_a), ldcfg_pkg::PARTNER_ADDR_MID))
      else $error("partner address not taken from straps");

   own_write_a: assert property ( // [RULE1]
      (cfg_ready && wr_stb && addr == ldcfg_pkg::REG_OWN_ADDR)
         |=> own_link_address == $past(wdata[7:1]) && rdata == 8'h00)
      else $error("own address write not stored");

   spread_low_a: assert property ( // [RULE3]
      ($rose(cfg_ready) && !$past(spread_strap_pin)) |-> spread_mode == ldcfg_pkg::LDCFG_SPREAD_OFF)
      else $error("spread default wrong with strap low");

   spread_high_a: assert property ( // [RULE4]
      ($rose(cfg_ready) && $past(spread_strap_pin)) |-> spread_mode == ldcfg_pkg::LDCFG_SPREAD_2PCT)
      else $error("spread default wrong with strap high");

   spread_write_a: assert property ( // [RULE3]
      (cfg_ready && wr_stb && addr == ldcfg_pkg::REG_SPREAD_CFG)
         |=> spread_mode == (($past(wdata[7:6]) == ldcfg_pkg::SS_4PCT) ? ldcfg_pkg::LDCFG_SPREAD_4PCT :
                             ($past(wdata[7:6]) == ldcfg_pkg::SS_2PCT) ? ldcfg_pkg::LDCFG_SPREAD_2PCT :
                             ldcfg_pkg::LDCFG_SPREAD_OFF))
      else $error("spread mode does not follow written code");

   pclk_fixed_a: assert property ( // [RULE5]
      (cfg_ready && st_q.prng != ldcfg_pkg::RANGE_AUTO && $stable(st_q.prng))
         |=> !pclk_auto && pclk_range == $past(st_q.prng))
      else $error("fixed pixel range not applied");

   pclk_auto_a: assert property ( // [RULE6]
      (cfg_ready && st_q.prng == ldcfg_pkg::RANGE_AUTO) |=> pclk_auto && pclk_range == $past(pclk_detect_range))
      else $error("pixel range auto detect not applied");

   rate_fixed_a: assert property ( // [RULE7]
      (cfg_ready && st_q.srng != ldcfg_pkg::RANGE_AUTO) |=> !rate_auto && rate_range == $past(st_q.srng))
      else $error("fixed serial rate range not applied");

   rate_auto_a: assert property ( // [RULE8]
      (cfg_ready && st_q.srng == ldcfg_pkg::RANGE_AUTO) |=> rate_auto && rate_range == $past(rate_detect_range))
      else $error("serial rate auto detect not applied");

   reserved_zero_a: assert property ( // [RULE9]
      (rd_stb && (addr == ldcfg_pkg::REG_OWN_ADDR || addr == ldcfg_pkg::REG_PARTNER_ADDR))
         |=> rdata[0] == 1'b0)
      else $error("reserved address bit reads nonzero");

   read_once_a: assert property ( // [RULE9]
      !rd_stb |=> rdata == 8'h00)
      else $error("read data present without read strobe");

   // Register stores and holds

   partner_write_a: assert property ( // [RULE2]
      (cfg_ready && wr_stb && addr == ldcfg_pkg::REG_PARTNER_ADDR)
         |=> partner_link_address == $past(wdata[7:1]))
      else $error("partner address write not stored");

   own_hold_a: assert property ( // [RULE1]
      (cfg_ready && !(wr_stb && addr == ldcfg_pkg::REG_OWN_ADDR))
         |=> $stable(own_link_address))
      else $error("own address changed without a write");

   partner_hold_a: assert property ( // [RULE2]
      (cfg_ready && !(wr_stb && addr == ldcfg_pkg::REG_PARTNER_ADDR))
         |=> $stable(partner_link_address))
      else $error("partner address changed without a write");

   spread_hold_a: assert property ( // [RULE3]
      (cfg_ready && !(wr_stb && addr == ldcfg_pkg::REG_SPREAD_CFG))
         |=> $stable(spread_mode))
      else $error("spread mode changed without a write");

   status_ro_a: assert property ( // [RULE9]
      (cfg_ready && wr_stb && addr == ldcfg_pkg::REG_RANGE_STATUS)
         |=> $stable(own_link_address) && $stable(partner_link_address) && $stable(spread_mode))
      else $error("write to status register changed state");

   // Range fields reach the outputs one cycle after the field itself

   pclk_write_a: assert property ( // [RULE5]
      (cfg_ready && wr_stb && addr == ldcfg_pkg::REG_SPREAD_CFG && wdata[3:2] != ldcfg_pkg::RANGE_AUTO)
         |-> ##2 !pclk_auto && pclk_range == $past(wdata[3:2], 2))
      else $error("written pixel range not applied");

   pclk_auto_on_a: assert property ( // [RULE6]
      (cfg_ready && wr_stb && addr == ldcfg_pkg::REG_SPREAD_CFG && wdata[3:2] == ldcfg_pkg::RANGE_AUTO)
         |-> ##2 pclk_auto)
      else $error("pixel range auto flag not raised");

   rate_write_a: assert property ( // [RULE7]
      (cfg_ready && wr_stb && addr == ldcfg_pkg::REG_SPREAD_CFG && wdata[1:0] != ldcfg_pkg::RANGE_AUTO)
         |-> ##2 !rate_auto && rate_range == $past(wdata[1:0], 2))
      else $error("written serial rate range not applied");

   rate_auto_on_a: assert property ( // [RULE8]
      (cfg_ready && wr_stb && addr == ldcfg_pkg::REG_SPREAD_CFG && wdata[1:0] == ldcfg_pkg::RANGE_AUTO)
         |-> ##2 rate_auto)
      else $error("serial rate auto flag not raised");

   // Read data

   read_own_a: assert property ( // [RULE1]
      (cfg_ready && rd_stb && addr == ldcfg_pkg::REG_OWN_ADDR)
         |=> rdata == {$past(own_link_address), 1'b0})
      else $error("own address read back wrong");

   read_partner_a: assert property ( // [RULE2]
      (cfg_ready && rd_stb && addr == ldcfg_pkg::REG_PARTNER_ADDR)
         |=> rdata == {$past(partner_link_address), 1'b0})
      else $error("partner address read back wrong");

   read_spread_a: assert property ( // [RULE9]
      (cfg_ready && rd_stb && addr == ldcfg_pkg::REG_SPREAD_CFG)
         |=> rdata[5:4] == 2'b00)
      else $error("reserved spread register bits read nonzero");

   read_status_a: assert property ( // [RULE6]
      (cfg_ready && rd_stb && addr == ldcfg_pkg::REG_RANGE_STATUS)
         |=> rdata == {2'b00, $past(rate_auto), $past(pclk_auto), $past(pclk_range), $past(rate_range)})
      else $error("range status read back wrong");

   unmapped_read_a: assert property ( // [RULE9]
      (rd_stb && addr > ldcfg_pkg::REG_RANGE_STATUS)
         |=> rdata == 8'h00)
      else $error("unmapped address reads nonzero");

   strap_quiet_a: assert property ( // [RULE9]
      !cfg_ready
         |=> rdata == 8'h00)
      else $error("read data present before ready");

   cov_spread4_c: cover property (cfg_ready && wr_stb && addr == ldcfg_pkg::REG_SPREAD_CFG
                                  && wdata[7:6] == ldcfg_pkg::SS_4PCT);
   cov_pclk_auto_c: cover property (pclk_auto ##1 !pclk_auto);
   cov_rd_own_c: cover property (cfg_ready && rd_stb && addr == ldcfg_pkg::REG_OWN_ADDR);
   cov_strap_high_c: cover property ($rose(cfg_ready)
                                     && spread_mode == ldcfg_pkg::LDCFG_SPREAD_2PCT);
   cov_back2back_c: cover property (cfg_ready && wr_stb ##1 rd_stb);
endmodule

// >>> dv/tb.sv
// Self-checking testbench for the link deserializer configuration register bank
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, rst, wr_stb, rd_stb, spread_strap_pin, pclk_auto, rate_auto, cfg_ready;
   logic [7:0] addr, wdata, rdata;
   logic [1:0] address_strap_a, address_strap_b, pclk_detect_range, rate_detect_range;
   logic [1:0] spread_mode, pclk_range, rate_range;
   logic [6:0] own_link_address, partner_link_address;
   int err_total = 0;
   int n_tests = 0;
   int cyc = 0;
   logic [1:0] sp_exp [4] = '{2'h0, 2'h1, 2'h0, 2'h2};
   ldcfg_regs ldcfg_regs_i (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
      .rd_stb(rd_stb), .rdata(rdata), .address_strap_a(address_strap_a), .address_strap_b(address_strap_b),
      .spread_strap_pin(spread_strap_pin), .pclk_detect_range(pclk_detect_range),
      .rate_detect_range(rate_detect_range), .own_link_address(own_link_address),
      .partner_link_address(partner_link_address), .spread_mode(spread_mode), .pclk_range(pclk_range),
      .pclk_auto(pclk_auto), .rate_range(rate_range), .rate_auto(rate_auto), .cfg_ready(cfg_ready));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic tally_and_finish();
      $display("comparisons %0d, mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // Hang guard: the whole sequence needs well under a thousand cycles
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         err_total++;
         tally_and_finish();
      end
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr_stb <= 1'b1;
      @(posedge clk);
      wr_stb <= 1'b0;
      #1;
   endtask
   // Read data stand only in the cycle after the strobe, then fall back to zero
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      addr <= a;
      rd_stb <= 1'b1;
      @(posedge clk);
      rd_stb <= 1'b0;
      #1;
      d = rdata;
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      rd(a, d);
      chk(d, exp);
   endtask
   // Straps are only captured on the first edge after release, so each reset gets its own set
   task automatic do_reset(input logic [1:0] sa, input logic [1:0] sb, input logic ss);
      @(posedge clk);
      rst <= 1'b1;
      address_strap_a <= sa;
      address_strap_b <= sb;
      spread_strap_pin <= ss;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      repeat (3) @(posedge clk);
      #1;
      chk(cfg_ready, 1'b1);
      chk(own_link_address, {sb, ldcfg_pkg::OWN_ADDR_MID, sa, 1'b0});
      chk(partner_link_address, {sb, ldcfg_pkg::PARTNER_ADDR_MID, sa, 1'b0});
      chk(spread_mode, ss ? 2'h1 : 2'h0);
      rd_chk(ldcfg_pkg::REG_OWN_ADDR, {sb, ldcfg_pkg::OWN_ADDR_MID, sa, 2'h0});
      rd_chk(ldcfg_pkg::REG_PARTNER_ADDR, {sb, ldcfg_pkg::PARTNER_ADDR_MID, sa, 2'h0});
      rd_chk(ldcfg_pkg::REG_SPREAD_CFG, {ss ? 2'h1 : 2'h0, 2'h0, 2'h3, 2'h3});
   endtask
   initial begin
      logic [7:0] d;
      rst = 1'b1;
      addr = 8'h00;
      wdata = 8'h00;
      wr_stb = 1'b0;
      rd_stb = 1'b0;
      address_strap_a = 2'h2;
      address_strap_b = 2'h1;
      spread_strap_pin = 1'b1;
      pclk_detect_range = 2'h2;
      rate_detect_range = 2'h1;
      do_reset(2'h2, 2'h1, 1'b1);
      rd_chk(ldcfg_pkg::REG_RANGE_STATUS, 8'h39);
      // Address write with the reserved bit set, then a read and the idle cycle after it
      wr(ldcfg_pkg::REG_OWN_ADDR, 8'hA5);
      chk(own_link_address, 7'h52);
      rd(ldcfg_pkg::REG_OWN_ADDR, d);
      chk(d, 8'hA4);
      @(posedge clk);
      #1;
      chk(rdata, 8'h00);
      // Write then read with no idle cycle between the strobes
      @(posedge clk);
      addr <= ldcfg_pkg::REG_OWN_ADDR;
      wdata <= 8'h5A;
      wr_stb <= 1'b1;
      @(posedge clk);
      wr_stb <= 1'b0;
      rd_stb <= 1'b1;
      @(posedge clk);
      rd_stb <= 1'b0;
      #1;
      chk(rdata, 8'h5A);
      wr(ldcfg_pkg::REG_PARTNER_ADDR, 8'h37);
      chk(partner_link_address, 7'h1B);
      rd_chk(ldcfg_pkg::REG_PARTNER_ADDR, 8'h36);
      for (int i = 0; i < 4; i++) begin
         wr(ldcfg_pkg::REG_SPREAD_CFG, {i[1:0], 2'h3, 4'hF});
         chk(spread_mode, sp_exp[i]);
         rd_chk(ldcfg_pkg::REG_SPREAD_CFG, {i[1:0], 6'h0F});
      end
      for (int i = 0; i < 4; i++) begin
         wr(ldcfg_pkg::REG_SPREAD_CFG, {2'h0, 2'h0, i[1:0], i[1:0]});
         @(posedge clk);
         #1;
         chk(pclk_range, (i == 3) ? pclk_detect_range : i[1:0]);
         chk(rate_range, (i == 3) ? rate_detect_range : i[1:0]);
         chk(pclk_auto, i == 3);
         chk(rate_auto, i == 3);
      end
      // Auto mode must follow the detector when it moves
      @(posedge clk);
      pclk_detect_range <= 2'h0;
      rate_detect_range <= 2'h2;
      repeat (2) @(posedge clk);
      #1;
      chk(pclk_range, 2'h0);
      chk(rate_range, 2'h2);
      rd_chk(ldcfg_pkg::REG_RANGE_STATUS, 8'h32);
      // Unmapped and read-only places
      wr(8'h03, 8'hFF);
      rd_chk(ldcfg_pkg::REG_RANGE_STATUS, 8'h32);
      wr(8'h10, 8'hFF);
      rd_chk(8'h10, 8'h00);
      do_reset(2'h0, 2'h2, 1'b0);
      tally_and_finish();
   end
endmodule
